// ### rtl/dac_gain_offset_correction.sv
// corrected-code sequencer, coefficient store, readback and analog update control
`timescale 1ns/1ps
`default_nettype none
module dac_gain_offset_correction
	import dgoc_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   nrst,
	input  wire logic                   wrValid,
	input  wire logic [1:0]             wrChanMask,
	input  wire logic [3:0]             wrDac,
	input  wire logic [15:0]            wrData,
	output logic                        wrReady,
	input  wire logic                   coefWr,
	input  wire logic                   coefIsGain,
	input  wire logic                   coefCh,
	input  wire logic [4:0]             coefSlot,
	input  wire logic [15:0]            coefData,
	input  wire logic                   ctrlWr,
	input  wire logic                   ctrlCalEnable,
	input  wire logic [1:0]             loadEnable,
	input  wire logic                   diffCompare,
	input  wire logic [1:0]             pmuForceCurrent,
	input  wire logic [1:0][2:0]        pmuRange,
	input  wire logic                   rdValid,
	input  wire logic                   rdCh,
	input  wire logic [3:0]             rdDac,
	output logic                        rdAck,
	output logic [15:0]                 rdData,
	input  wire logic                   csRelease,
	input  wire logic [1:0]             deferMode,
	input  wire logic [1:0]             dacLoad,
	output logic [1:0]                  dacUpdate,
	output logic [1:0][15:0][15:0]      physLevel,
	output logic                        calEnable
);
	// coefficient store; no reset so contents live through every reset
	logic [15:0] gainMem [NUM_CH][NUM_SLOT] = '{default: GAIN_RESET};
	logic [15:0] offsetMem [NUM_CH][NUM_SLOT] = '{default: OFFSET_RESET};

	dgoc_state_type        state_reg, state_next;
	logic [1:0]            todo_reg, todo_next;
	logic [1:0]            dirty_reg, dirty_next;
	logic [1:0]            loadPend_reg, loadPend_next;
	logic                  csPend_reg, csPend_next;
	logic                  curCh_reg, curCh_next;
	logic [3:0]            dac_reg, dac_next;
	logic [15:0]           code_reg, code_next;
	logic                  bypass_reg, bypass_next;
	logic [1:0][4:0]       slot_reg, slot_next;
	logic                  calEnable_reg, calEnable_next;
	logic                  wrReady_reg, wrReady_next;
	logic                  rdAck_reg, rdAck_next;
	logic [15:0]           rdData_reg, rdData_next;
	logic [1:0]            dacUpdate_reg, dacUpdate_next;
	logic [1:0][15:0][15:0] x2_reg, x2_next;
	logic [1:0][15:0][15:0] phys_reg, phys_next;
	logic                  accept;
	logic                  store;

	dgoc_corr_if corr ();

	dgoc_corr_unit u_corr (
		.clk  (clk),
		.nrst (nrst),
		.cu   (corr.unit)
	);

	// ------------------------------------------------------------
	// coefficient pair selection
	// ------------------------------------------------------------
	function automatic logic [4:0] pickSlot(input logic [3:0] dac, input logic ch);
		logic [4:0] s;
		s = {1'b0, dac};
		if (dac == DAC_TERM && loadEnable[ch]) begin
			s = {1'b0, dac} + SLOT_ALT;
		end else if ((dac == DAC_CMP_HI || dac == DAC_CMP_LO) && !ch && diffCompare) begin
			s = {1'b0, dac} + SLOT_ALT;
		end else if (dac == DAC_PMU && pmuForceCurrent[ch]) begin
			s = SLOT_PMU_FI + {2'b00, pmuRange[ch]};
		end
		return s;
	endfunction

	always_ff @(posedge clk) begin
		if (coefWr && coefIsGain) begin
			gainMem[coefCh][coefSlot] <= coefData;
		end
		if (coefWr && !coefIsGain) begin
			offsetMem[coefCh][coefSlot] <= coefData;
		end
	end

	// ------------------------------------------------------------
	// write sequencer
	// ------------------------------------------------------------
	assign accept = wrReady_reg && wrValid && (wrChanMask != 2'b00);
	assign store  = (state_reg == ST_WAIT) && corr.done;

	assign corr.start  = (state_reg == ST_CALC);
	assign corr.bypass = bypass_reg;
	assign corr.code   = code_reg;
	assign corr.gain   = gainMem[curCh_reg][slot_reg[curCh_reg]];
	assign corr.offset = offsetMem[curCh_reg][slot_reg[curCh_reg]];

	always_comb begin
		state_next = state_reg;
		todo_next  = todo_reg;
		curCh_next = curCh_reg;
		dac_next   = dac_reg;
		code_next  = code_reg;
		bypass_next = bypass_reg;
		slot_next  = slot_reg;
		x2_next    = x2_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (accept) begin
					todo_next   = wrChanMask;
					curCh_next  = !wrChanMask[0];
					dac_next    = wrDac;
					code_next   = wrData;
					bypass_next = !calEnable_reg;
					slot_next[0] = pickSlot(wrDac, 1'b0);
					slot_next[1] = pickSlot(wrDac, 1'b1);
					state_next  = ST_CALC;
				end
			end
			ST_CALC: begin
				state_next = ST_WAIT;
			end
			ST_WAIT: begin
				if (corr.done) begin
					x2_next[curCh_reg][dac_reg] = corr.result;
					todo_next[curCh_reg] = 1'b0;
					if (!curCh_reg && todo_reg[1]) begin
						curCh_next = 1'b1;
						state_next = ST_CALC;
					end else begin
						state_next = ST_IDLE;
					end
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	// ------------------------------------------------------------
	// analog update, readback and control
	// ------------------------------------------------------------
	always_comb begin
		wrReady_next   = (state_next == ST_IDLE);
		calEnable_next = ctrlWr ? ctrlCalEnable : calEnable_reg;
		rdAck_next     = rdValid;
		rdData_next    = rdValid ? x2_reg[rdCh][rdDac] : rdData_reg;
		dirty_next     = dirty_reg;
		loadPend_next  = loadPend_reg | dacLoad;
		csPend_next    = csPend_reg | csRelease;
		dacUpdate_next = 2'b00;
		phys_next      = phys_reg;
		if (store) begin
			dirty_next[curCh_reg] = 1'b1;
		end
		// transfers wait until no write is in flight, so both non-deferred channels of a
		// dual write reach the dacs from the same select release
		if (state_reg == ST_IDLE) begin
			for (int c = 0; c < NUM_CH; c++) begin
				if ((csPend_next && !deferMode[c] && dirty_reg[c])
					|| (loadPend_next[c] && deferMode[c])) begin
					phys_next[c]      = x2_reg[c];
					dacUpdate_next[c] = 1'b1;
					dirty_next[c]     = 1'b0;
				end
			end
			csPend_next   = 1'b0;
			loadPend_next = 2'b00;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg     <= ST_IDLE;
			todo_reg      <= 2'b00;
			curCh_reg     <= 1'b0;
			dac_reg       <= 4'h0;
			code_reg      <= CODE_RESET;
			bypass_reg    <= 1'b1;
			slot_reg      <= '0;
			x2_reg        <= '0;
			phys_reg      <= '0;
			dirty_reg     <= 2'b00;
			loadPend_reg  <= 2'b00;
			csPend_reg    <= 1'b0;
			calEnable_reg <= 1'b0;
			wrReady_reg   <= 1'b0;
			rdAck_reg     <= 1'b0;
			rdData_reg    <= CODE_RESET;
			dacUpdate_reg <= 2'b00;
		end else begin
			state_reg     <= state_next;
			todo_reg      <= todo_next;
			curCh_reg     <= curCh_next;
			dac_reg       <= dac_next;
			code_reg      <= code_next;
			bypass_reg    <= bypass_next;
			slot_reg      <= slot_next;
			x2_reg        <= x2_next;
			phys_reg      <= phys_next;
			dirty_reg     <= dirty_next;
			loadPend_reg  <= loadPend_next;
			csPend_reg    <= csPend_next;
			calEnable_reg <= calEnable_next;
			wrReady_reg   <= wrReady_next;
			rdAck_reg     <= rdAck_next;
			rdData_reg    <= rdData_next;
			dacUpdate_reg <= dacUpdate_next;
		end
	end

	assign wrReady   = wrReady_reg;
	assign rdAck     = rdAck_reg;
	assign rdData    = rdData_reg;
	assign dacUpdate = dacUpdate_reg;
	assign physLevel = phys_reg;
	assign calEnable = calEnable_reg;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence chZeroStore;
		store && !curCh_reg;
	endsequence
	sequence chOneStore;
		store && curCh_reg;
	endsequence

	cal_reset_a: assert property (@(posedge clk) disable iff (!nrst)
		$past(!nrst) |-> !calEnable_reg)
		else $error("correction enable not cleared by reset");
	x2_hold_a: assert property (@(posedge clk) disable iff (!nrst)
		!$past(store) |-> x2_reg == $past(x2_reg))
		else $error("corrected register changed without a data write");
	read_back_a: assert property (@(posedge clk) disable iff (!nrst)
		rdValid |=> rdAck_reg && rdData_reg == $past(x2_reg[rdCh][rdDac]))
		else $error("readback is not the corrected register");
	dual_write_a: assert property (@(posedge clk) disable iff (!nrst)
		accept && wrChanMask == 2'b11 |-> ##2 chZeroStore ##2 chOneStore)
		else $error("dual write did not update both channels in turn");
	bypass_state_a: assert property (@(posedge clk) disable iff (!nrst)
		accept |=> bypass_reg == !$past(calEnable_reg))
		else $error("bypass not taken from the enable bit");
	imm_update_a: assert property (@(posedge clk) disable iff (!nrst)
		csRelease && state_reg == ST_IDLE && dirty_reg[0] && !deferMode[0]
		|=> dacUpdate_reg[0])
		else $error("immediate channel did not update after select release");
	defer_hold_a: assert property (@(posedge clk) disable iff (!nrst)
		deferMode[1] && !dacLoad[1] && !loadPend_reg[1] |=> !dacUpdate_reg[1])
		else $error("deferred channel updated without its load bit");
	phys_copy_a: assert property (@(posedge clk) disable iff (!nrst)
		dacUpdate_reg[0] |-> phys_reg[0] == $past(x2_reg[0]))
		else $error("physical dac did not receive the corrected register");
	pmu_slot_a: assert property (@(posedge clk) disable iff (!nrst)
		accept && wrDac == DAC_PMU && pmuForceCurrent[0]
		|=> slot_reg[0] == SLOT_PMU_FI + {2'b00, $past(pmuRange[0])})
		else $error("pmu coefficient pair not taken from mode and range");
endmodule
`default_nettype wire

// ### rtl/dgoc_corr_unit.sv
// one-cycle gain and offset arithmetic with saturation
`timescale 1ns/1ps
`default_nettype none
module dgoc_corr_unit
	import dgoc_pkg::*;
(
	input  wire logic clk,
	input  wire logic nrst,
	dgoc_corr_if.unit cu
);
	logic [15:0]        result_reg;
	logic [15:0]        result_next;
	logic               done_reg;
	logic [32:0]        prod;
	logic signed [18:0] sum;

	// ------------------------------------------------------------
	// arithmetic
	// ------------------------------------------------------------
	always_comb begin
		prod = 33'({1'b0, cu.gain} + GAIN_ONE) * 33'(cu.code);
		sum  = $signed({2'b00, prod[32:16]}) + $signed({3'b000, cu.offset})
			- $signed(OFFSET_BIAS);
		if (cu.bypass) begin
			result_next = cu.code;
		end else if (sum < 0) begin
			result_next = CODE_RESET;
		end else if (sum > $signed(SUM_MAX)) begin
			result_next = FULL_SCALE;
		end else begin
			result_next = sum[15:0];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			result_reg <= CODE_RESET;
			done_reg   <= 1'b0;
		end else begin
			result_reg <= cu.start ? result_next : result_reg;
			done_reg   <= cu.start;
		end
	end

	assign cu.result = result_reg;
	assign cu.done   = done_reg;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	bypass_pass_a: assert property (@(posedge clk) disable iff (!nrst)
		cu.start && cu.bypass |=> cu.done && cu.result == $past(cu.code))
		else $error("bypass did not pass the written code");
	unity_coef_a: assert property (@(posedge clk) disable iff (!nrst)
		cu.start && !cu.bypass && cu.gain == GAIN_RESET && cu.offset == OFFSET_RESET
		|=> cu.result == $past(cu.code))
		else $error("default coefficients changed the code");
endmodule
`default_nettype wire

// ### shared/dgoc_corr_if.sv
// request and answer between the sequencer and the arithmetic unit
`timescale 1ns/1ps
`default_nettype none
interface dgoc_corr_if;
	logic        start;
	logic        bypass;
	logic [15:0] code;
	logic [15:0] gain;
	logic [15:0] offset;
	logic        done;
	logic [15:0] result;
	modport client (output start, output bypass, output code, output gain, output offset,
		input done, input result);
	modport unit (input start, input bypass, input code, input gain, input offset,
		output done, output result);
endinterface
`default_nettype wire

// ### shared/dgoc_pkg.sv
// constants and types for the dac gain and offset correction datapath
package dgoc_pkg;
	localparam int          CODE_W       = 16;
	localparam int          NUM_CH       = 2;
	localparam int          NUM_DAC      = 16;
	localparam int          DAC_W        = 4;
	localparam int          NUM_SLOT     = 32;
	localparam int          SLOT_W       = 5;
	localparam int          RANGE_W      = 3;
	localparam logic [15:0] GAIN_RESET   = 16'hFFFF;
	localparam logic [15:0] OFFSET_RESET = 16'h8000;
	localparam logic [15:0] CODE_RESET   = 16'h0000;
	localparam logic [15:0] FULL_SCALE   = 16'hFFFF;
	localparam logic [16:0] GAIN_ONE     = 17'h00001;
	localparam logic [18:0] OFFSET_BIAS  = 19'h08000;
	localparam logic [18:0] SUM_MAX      = 19'h0FFFF;
	// dac indices with more than one coefficient pair
	localparam logic [3:0]  DAC_TERM     = 4'h1;
	localparam logic [3:0]  DAC_CMP_HI   = 4'h5;
	localparam logic [3:0]  DAC_CMP_LO   = 4'h6;
	localparam logic [3:0]  DAC_PMU      = 4'h9;
	// alternate pair lives at dac index plus this
	localparam logic [4:0]  SLOT_ALT     = 5'h10;
	// forced-current pmu pairs start here, one per range
	localparam logic [4:0]  SLOT_PMU_FI  = 5'h1A;
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_CALC  = 2'b01,
		ST_WAIT  = 2'b10
	} dgoc_state_type;
endpackage

// ### verification/dac_gain_offset_correction_tb.sv
// self-checking bench for the dac gain and offset correction datapath
`timescale 1ns/1ps
`default_nettype none
module dac_gain_offset_correction_tb
	import dgoc_pkg::*;
();
	logic clk, nrst, wrReady, wrValid, coefWr, coefIsGain, coefCh, ctrlWr, ctrlCalEnable;
	logic rdValid, rdCh, rdAck, csRelease, diffCompare, calEnable, calModel;
	logic [1:0] wrChanMask, loadEnable, pmuForceCurrent, deferMode, dacLoad, dacUpdate;
	logic [3:0] wrDac, rdDac;
	logic [4:0] coefSlot;
	logic [15:0] wrData, coefData, rdData, lfsrState;
	logic [1:0][2:0] pmuRange;
	logic [1:0][15:0][15:0] physLevel;
	logic [15:0] gm [2][32], om [2][32], x2m [2][16], rdQ [$];
	logic [20:0] upQ [$], e, upE;
	int fail_count, samples_checked, cyc;
	dac_gain_offset_correction DUT (.clk, .nrst, .wrValid, .wrChanMask, .wrDac, .wrData,
		.wrReady, .coefWr, .coefIsGain, .coefCh, .coefSlot, .coefData, .ctrlWr, .ctrlCalEnable,
		.loadEnable, .diffCompare, .pmuForceCurrent, .pmuRange, .rdValid, .rdCh, .rdDac, .rdAck,
		.rdData, .csRelease, .deferMode, .dacLoad, .dacUpdate, .physLevel, .calEnable);
	dgoc_host_model h (.clk, .wrReady, .wrValid, .wrChanMask, .wrDac, .wrData, .coefWr,
		.coefIsGain, .coefCh, .coefSlot, .coefData, .ctrlWr, .ctrlCalEnable, .rdValid, .rdCh,
		.rdDac, .csRelease, .dacLoad);
	// ----------------------------------------
	// reference model and checks
	// ----------------------------------------
	function automatic logic [15:0] rnd();
		lfsrState = {lfsrState[14:0], lfsrState[15] ^ lfsrState[13] ^ lfsrState[12] ^ lfsrState[10]};
		return lfsrState;
	endfunction
	function automatic logic [15:0] corr(logic [15:0] g, logic [15:0] o, logic [15:0] x);
		logic [33:0] p;
		logic signed [19:0] s;
		p = ({17'h00000, g} + 34'h000000001) * {18'h00000, x};
		s = $signed({3'h0, p[32:16]}) + $signed({4'h0, o}) - 20'sh08000;
		return (s < 0) ? 16'h0000 : ((s > 20'sh0FFFF) ? 16'hFFFF : s[15:0]);
	endfunction
	// coefficient pair that the mode and range levels select for a write
	function automatic logic [4:0] slotOf(input int c, input logic [3:0] d);
		if (d == DAC_TERM && loadEnable[c]) return {1'b1, d};
		if ((d == DAC_CMP_HI || d == DAC_CMP_LO) && c == 0 && diffCompare) return {1'b1, d};
		if (d == DAC_PMU && pmuForceCurrent[c]) return SLOT_PMU_FI + {2'b00, pmuRange[c]};
		return {1'b0, d};
	endfunction
	task automatic chk(input string n, input logic [15:0] ex, input logic [15:0] g);
		samples_checked++;
		if (g !== ex) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", n, ex, g);
		end
	endtask
	task automatic setc(input logic g, input logic c, input logic [4:0] s, input logic [15:0] v);
		if (g) gm[c][s] = v;
		else om[c][s] = v;
		h.coef(g, c, s, v);
	endtask
	task automatic put(input logic [1:0] m, input logic [3:0] d, input logic [15:0] x);
		logic [4:0] s;
		for (int c = 0; c < 2; c++) begin
			s = slotOf(c, d);
			if (m[c]) x2m[c][d] = calModel ? corr(gm[c][s], om[c][s], x) : x;
		end
		h.wr(m, d, x);
	endtask
	task automatic rdc(input logic c, input logic [3:0] d);
		rdQ.push_back(x2m[c][d]);
		h.rd(c, d);
	endtask
	task automatic doReset();
		// let an outstanding read answer land before reset clears it
		repeat (2) @(posedge clk);
		nrst <= 1'b0;
		calModel = 1'b0;
		foreach (x2m[c, d]) x2m[c][d] = CODE_RESET;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
		chk("calEnable", 16'h0000, {15'h0000, calEnable});
	endtask
	task automatic enable();
		h.ctrl(1'b1);
		calModel = 1'b1;
		@(posedge clk);
		chk("calEnable", 16'h0001, {15'h0000, calEnable});
	endtask
	task automatic summarize();
		if (fail_count == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	always @(posedge clk) begin
		if (rdAck === 1'b1) chk("rdData", (rdQ.size() > 0) ? rdQ.pop_front() : 16'hXXXX, rdData);
		for (int c = 0; c < 2; c++) begin
			if (dacUpdate[c] === 1'b1) begin
				upE = (upQ.size() > 0) ? upQ.pop_front() : 'x;
				chk("updCh", {15'h0000, upE[20]}, {15'h0000, c[0]});
				chk("physLevel", upE[15:0], physLevel[c][upE[19:16]]);
				for (int d = 0; d < 16; d++) chk("physRow", x2m[c][d], physLevel[c][d]);
			end
		end
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			fail_count++;
			summarize();
		end
	end
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		{nrst, loadEnable, deferMode, diffCompare, pmuForceCurrent, pmuRange} = '0;
		lfsrState = 16'h523B;
		foreach (gm[c, s]) {gm[c][s], om[c][s]} = {GAIN_RESET, OFFSET_RESET};
		doReset();
		put(2'b01, 4'h2, rnd());
		rdc(1'b0, 4'h2);
		for (int i = 0; i < 4; i++) setc(i[0], i[1], 5'h02, rnd());
		put(2'b11, 4'h2, rnd());
		rdc(1'b0, 4'h2);
		rdc(1'b1, 4'h2);
		enable();
		put(2'b11, 4'h2, rnd());
		rdc(1'b0, 4'h2);
		rdc(1'b1, 4'h2);
		setc(1'b1, 1'b0, 5'h02, rnd());
		rdc(1'b0, 4'h2);
		put(2'b01, 4'h3, rnd());
		rdc(1'b0, 4'h3);
		setc(1'b0, 1'b0, 5'h04, 16'h0000);
		put(2'b01, 4'h4, 16'h1234);
		rdc(1'b0, 4'h4);
		setc(1'b0, 1'b0, 5'h04, 16'hFFFF);
		put(2'b01, 4'h4, 16'hF000);
		rdc(1'b0, 4'h4);
		for (int i = 0; i < 2; i++) setc(i[0], 1'b0, 5'h11, rnd());
		loadEnable <= 2'b01;
		@(posedge clk);
		put(2'b11, DAC_TERM, rnd());
		rdc(1'b0, DAC_TERM);
		rdc(1'b1, DAC_TERM);
		loadEnable <= 2'b00;
		@(posedge clk);
		put(2'b01, DAC_TERM, rnd());
		rdc(1'b0, DAC_TERM);
		diffCompare <= 1'b1;
		pmuForceCurrent <= 2'b11;
		pmuRange <= {3'h4, 3'h2};
		@(posedge clk);
		for (int i = 0; i < 2; i++) setc(i[0], 1'b0, 5'h15, rnd());
		for (int i = 0; i < 4; i++) setc(i[0], i[1], i[1] ? 5'h1E : 5'h1C, rnd());
		for (int i = 0; i < 2; i++) begin
			put(2'b11, i[0] ? DAC_PMU : DAC_CMP_HI, rnd());
			rdc(1'b0, i[0] ? DAC_PMU : DAC_CMP_HI);
			rdc(1'b1, i[0] ? DAC_PMU : DAC_CMP_HI);
		end
		for (int i = 0; i < 6; i++) begin
			e = {5'h00, rnd()};
			setc(e[8], e[0], {1'b0, e[7:4]}, rnd());
			put((e[1:0] == 2'b00) ? 2'b11 : e[1:0], e[7:4], rnd());
			for (int c = 0; c < 2; c++) if (e[c] || e[1:0] == 2'b00) rdc(c[0], e[7:4]);
		end
		doReset();
		rdc(1'b1, 4'h2);
		enable();
		put(2'b11, 4'h2, rnd());
		rdc(1'b0, 4'h2);
		rdc(1'b1, 4'h2);
		@(posedge clk);
		deferMode <= 2'b10;
		put(2'b11, 4'h7, rnd());
		upQ.push_back({1'b0, 4'h7, x2m[0][7]});
		h.pulse(1'b1, 2'b00);
		repeat (4) @(posedge clk);
		upQ.push_back({1'b1, 4'h7, x2m[1][7]});
		h.pulse(1'b0, 2'b11);
		h.pulse(1'b1, 2'b00);
		repeat (4) @(posedge clk);
		chk("pending", 16'h0000, 16'(rdQ.size() + upQ.size()));
		summarize();
	end
endmodule
`default_nettype wire

// ### verification/dgoc_host_model.sv
// serial host model that drives level, coefficient, control and update requests
`timescale 1ns/1ps
`default_nettype none
module dgoc_host_model
	import dgoc_pkg::*;
(
	input  wire logic   clk,
	input  wire logic   wrReady,
	output logic        wrValid,
	output logic [1:0]  wrChanMask,
	output logic [3:0]  wrDac,
	output logic [15:0] wrData,
	output logic        coefWr,
	output logic        coefIsGain,
	output logic        coefCh,
	output logic [4:0]  coefSlot,
	output logic [15:0] coefData,
	output logic        ctrlWr,
	output logic        ctrlCalEnable,
	output logic        rdValid,
	output logic        rdCh,
	output logic [3:0]  rdDac,
	output logic        csRelease,
	output logic [1:0]  dacLoad
);
	// ----------------------------------------
	// request tasks
	// ----------------------------------------
	initial begin
		{wrValid, wrChanMask, wrDac, coefWr, coefIsGain, coefCh, coefSlot} = '0;
		{ctrlWr, ctrlCalEnable, rdValid, rdCh, rdDac, csRelease, dacLoad} = '0;
		wrData = 16'hA5A5;
		coefData = 16'h5A5A;
	end
	// hold the write until taken, released data lines show the inverse
	task automatic wr(input logic [1:0] m, input logic [3:0] d, input logic [15:0] x);
		@(posedge clk);
		{wrValid, wrChanMask, wrDac, wrData} <= {1'b1, m, d, x};
		@(posedge clk);
		while (wrReady !== 1'b1) @(posedge clk);
		wrValid <= 1'b0;
		wrData <= ~x;
		@(posedge clk);
		while (wrReady !== 1'b1) @(posedge clk);
	endtask
	task automatic coef(input logic g, input logic c, input logic [4:0] s, input logic [15:0] v);
		@(posedge clk);
		{coefWr, coefIsGain, coefCh, coefSlot, coefData} <= {1'b1, g, c, s, v};
		@(posedge clk);
		coefWr <= 1'b0;
		coefData <= ~v;
	endtask
	task automatic ctrl(input logic en);
		@(posedge clk);
		{ctrlWr, ctrlCalEnable} <= {1'b1, en};
		@(posedge clk);
		ctrlWr <= 1'b0;
	endtask
	task automatic rd(input logic c, input logic [3:0] d);
		@(posedge clk);
		{rdValid, rdCh, rdDac} <= {1'b1, c, d};
		@(posedge clk);
		rdValid <= 1'b0;
	endtask
	task automatic pulse(input logic rel, input logic [1:0] ld);
		@(posedge clk);
		{csRelease, dacLoad} <= {rel, ld};
		@(posedge clk);
		{csRelease, dacLoad} <= 3'h0;
	endtask
endmodule
`default_nettype wire
